// File: core/ubaf_pkg.sv
// Behaviour
// - Every upstream signal is sampled on the rising upstream clock edge.
// - During upstream reset all upstream drivers float and all state resets.
// - During upstream reset downstream outputs are low; no bridging happens.
// - After reset release operation resumes from default state and values.
// - Address phase carries 32-bit address; following data phases carry data.
// - Byte-enable bit n qualifies data byte n, bit 0 on lines 7..0.
// - Address/data and command lines are two-way; current master drives them.
// - Even parity over both buses; as master, parity follows data one clock later.
// - Data phase completes only when initiator and target ready both asserted.
package ubaf_pkg;

   localparam int AD_W       = 32;
   localparam int CBE_W      = 4;
   localparam int BYTE_W     = 8;
   localparam int FIFO_DEPTH = 32;
   localparam int RST_STAGES = 2;

   // output enables are low while driving
   localparam logic OE_DRIVE = 1'b0;
   localparam logic OE_FLOAT = 1'b1;

   typedef enum logic {UBAF_IDLE, UBAF_DATA} ubaf_phase_t;

   // one word pushed towards the downstream side
   typedef struct packed {
      logic             isAddr;
      logic [CBE_W-1:0] cmdBe;
      logic [AD_W-1:0]  word;
   } ubaf_rec_t;

   localparam int REC_W = $bits(ubaf_rec_t);

   // what the device puts on the bus as master
   typedef struct packed {
      logic [AD_W-1:0]  ad;
      logic [CBE_W-1:0] cbe;
   } ubaf_drive_t;

   typedef struct packed {
      ubaf_phase_t      phase;
      logic             framePrev;
      logic [CBE_W-1:0] cmd;
      logic [AD_W-1:0]  adOut;
      logic [CBE_W-1:0] cbeOut;
      logic             busOeN;
      logic             parOut;
      logic             parOeN;
      logic             chkPend;
      logic             parExp;
      logic             parErr;
   } ubaf_state_t;

   localparam ubaf_state_t ST_RESET = '{
      phase:     UBAF_IDLE,
      framePrev: 1'b0,
      cmd:       4'h0,
      adOut:     32'h0000_0000,
      cbeOut:    4'h0,
      busOeN:    OE_FLOAT,
      parOut:    1'b0,
      parOeN:    OE_FLOAT,
      chkPend:   1'b0,
      parExp:    1'b0,
      parErr:    1'b0
   };

endpackage : ubaf_pkg

// File: core/ubaf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module ubaf_fifo #(
   parameter int WIDTH = 37,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rstN,
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   output logic                  outValid,
   input  wire logic             outReady,
   output logic      [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);

   typedef struct packed {
      logic [PW-1:0] wr;
      logic [PW-1:0] rd;
      logic [PW:0]   cnt;
   } ubaf_fptr_t;

   logic [WIDTH-1:0] mem [DEPTH];
   ubaf_fptr_t       f_q;
   ubaf_fptr_t       f_d;
   logic             push;
   logic             pop;

   // honest flags straight from the count
   assign inReady  = f_q.cnt != (PW+1)'(DEPTH);
   assign outValid = f_q.cnt != '0;
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   // empty reads as zero so nothing leaks out during reset
   assign outData  = outValid ? mem[f_q.rd] : '0;

   always_comb begin
      f_d = f_q;
      if (push) f_d.wr = f_q.wr + 1'b1;
      if (pop) f_d.rd = f_q.rd + 1'b1;
      f_d.cnt = f_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) f_q <= '0;
      else f_q <= f_d;
   end

   // storage needs no reset; only written words are ever read
   always_ff @(posedge clk) begin
      if (push) mem[f_q.wr] <= inData;
   end

endmodule : ubaf_fifo
`default_nettype wire

// File: core/ubaf_front.sv
`timescale 1ns/1ps
`default_nettype none
module ubaf_front (
   input  wire logic                       clk,
   input  wire logic                       nrst,
   // upstream bus, sampled every rising edge
   input  wire logic [ubaf_pkg::AD_W-1:0]  upAdIn,
   output logic      [ubaf_pkg::AD_W-1:0]  upAdOut,
   output logic                            upAdOeN,
   input  wire logic [ubaf_pkg::CBE_W-1:0] upCmdByteEnableIn,
   output logic      [ubaf_pkg::CBE_W-1:0] upCmdByteEnableOut,
   output logic                            upCmdByteEnableOeN,
   input  wire logic                       upParityLineIn,
   output logic                            upParityLineOut,
   output logic                            upParityLineOeN,
   input  wire logic                       upFrameN,
   input  wire logic                       upInitiatorReadyN,
   input  wire logic                       upTargetReadyN,
   // master side request from the bridge core
   input  wire logic                       upMasterDrive,
   input  wire ubaf_pkg::ubaf_drive_t      upDrive,
   // status
   output logic                            upParityErr,
   output logic                            upStall,
   // downstream side
   output logic                            dnValid,
   input  wire logic                       dnReady,
   output ubaf_pkg::ubaf_rec_t             dnRec
);

   ////////////////////////////////////////////////////////////////////////
   // reset release

   logic [ubaf_pkg::RST_STAGES-1:0] rstSync_q;
   logic                            rstN;

   // enters at once, leaves on a clock edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) rstSync_q <= '0;
      else rstSync_q <= {rstSync_q[ubaf_pkg::RST_STAGES-2:0], 1'b1};
   end

   assign rstN = rstSync_q[ubaf_pkg::RST_STAGES-1];

   ////////////////////////////////////////////////////////////////////////
   // phase decode

   ubaf_pkg::ubaf_state_t s_q;
   ubaf_pkg::ubaf_state_t s_d;
   logic                  addrStart;
   logic                  dataDone;
   logic                  push;
   logic                  fifoReady;
   ubaf_pkg::ubaf_rec_t   rec;
   logic [ubaf_pkg::AD_W-1:0] maskedData;
   logic                  sampleAd;

   // a new frame only counts when it was idle before
   assign addrStart = (s_q.phase == ubaf_pkg::UBAF_IDLE) && !upFrameN
                      && !s_q.framePrev;
   assign dataDone  = (s_q.phase == ubaf_pkg::UBAF_DATA) && !upInitiatorReadyN
                      && !upTargetReadyN;
   assign sampleAd  = addrStart || dataDone;
   assign push      = sampleAd;

   // disabled lanes are zeroed so the far side never sees stale bytes
   for (genvar b = 0; b < ubaf_pkg::CBE_W; b++) begin : g_lane
      assign maskedData[b*ubaf_pkg::BYTE_W +: ubaf_pkg::BYTE_W] =
         upCmdByteEnableIn[b] ? '0 : upAdIn[b*ubaf_pkg::BYTE_W +: ubaf_pkg::BYTE_W];
   end

   // address word carries the command, data words the enables
   always_comb begin
      rec.isAddr = addrStart;
      rec.cmdBe  = upCmdByteEnableIn;
      rec.word   = addrStart ? upAdIn : maskedData;
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d           = s_q;
      s_d.framePrev = !upFrameN;
      s_d.parErr    = 1'b0;
      s_d.chkPend   = 1'b0;
      s_d.busOeN    = ubaf_pkg::OE_FLOAT;
      // drive only while the core owns the cycle
      if (upMasterDrive) begin
         s_d.adOut  = upDrive.ad;
         s_d.cbeOut = upDrive.cbe;
         s_d.busOeN = ubaf_pkg::OE_DRIVE;
      end
      // parity trails the driven word by one clock
      s_d.parOeN = s_q.busOeN;
      s_d.parOut = ^{s_q.adOut, s_q.cbeOut};
      // check what another master put on the bus
      if (s_q.chkPend) s_d.parErr = upParityLineIn != s_q.parExp;
      if (sampleAd && s_q.busOeN == ubaf_pkg::OE_FLOAT) begin
         s_d.chkPend = 1'b1;
         s_d.parExp  = ^{upAdIn, upCmdByteEnableIn};
      end
      case (s_q.phase)
         ubaf_pkg::UBAF_IDLE: begin
            if (addrStart) begin
               s_d.phase = ubaf_pkg::UBAF_DATA;
               s_d.cmd   = upCmdByteEnableIn;
            end
         end
         ubaf_pkg::UBAF_DATA: begin
            // last phase ends on completion with frame gone
            if (upFrameN && (dataDone || upInitiatorReadyN)) begin
               s_d.phase = ubaf_pkg::UBAF_IDLE;
            end
         end
         default: s_d.phase = ubaf_pkg::UBAF_IDLE;
      endcase
   end

   // every edge samples; reset floats drivers and clears state
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) s_q <= ubaf_pkg::ST_RESET;
      else s_q <= s_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign upAdOut            = s_q.adOut;
   assign upAdOeN            = s_q.busOeN;
   assign upCmdByteEnableOut = s_q.cbeOut;
   assign upCmdByteEnableOeN = s_q.busOeN;
   assign upParityLineOut    = s_q.parOut;
   assign upParityLineOeN    = s_q.parOeN;
   assign upParityErr        = s_q.parErr;
   // a full buffer drops the word; the core must disconnect on this
   assign upStall            = !fifoReady;

   // fifo is held in reset too, so downstream stays low
   ubaf_fifo #(
      .WIDTH (ubaf_pkg::REC_W),
      .DEPTH (ubaf_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk      (clk),
      .rstN     (rstN),
      .inValid  (push),
      .inReady  (fifoReady),
      .inData   (rec),
      .outValid (dnValid),
      .outReady (dnReady),
      .outData  (dnRec)
   );

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstN);

   a_float_after_rst: assert property (
      $rose(rstN) |-> upAdOeN && upCmdByteEnableOeN && upParityLineOeN)
      else $error("bus driven right after reset");

   a_down_low_rst: assert property (
      $rose(rstN) |-> !dnValid && dnRec == '0)
      else $error("downstream not low after reset");

   a_idle_after_rst: assert property (
      $rose(rstN) |-> s_q.phase == ubaf_pkg::UBAF_IDLE && !upParityErr)
      else $error("state not default after reset");

   a_addr_word_kept: assert property (
      addrStart && fifoReady |-> push && rec.isAddr && rec.word == upAdIn
      ##1 s_q.phase == ubaf_pkg::UBAF_DATA)
      else $error("address phase not captured");

   a_cmd_stored: assert property (
      addrStart |=> s_q.cmd == $past(upCmdByteEnableIn))
      else $error("command not kept");

   a_lane_mask: assert property (
      push && !rec.isAddr && upCmdByteEnableIn[3] |-> rec.word[31:24] == 8'h00)
      else $error("disabled lane passed");

   a_master_drive: assert property (
      upMasterDrive |=> !upAdOeN && upAdOut == $past(upDrive.ad))
      else $error("master data not driven");

   a_parity_delay: assert property (
      !upAdOeN |=> !upParityLineOeN
      && upParityLineOut == ^{$past(upAdOut), $past(upCmdByteEnableOut)})
      else $error("parity not one clock late");

   a_parity_check: assert property (
      sampleAd && upAdOeN && !upMasterDrive ##1 upParityLineIn != $past(^{upAdIn,
      upCmdByteEnableIn}) |=> upParityErr)
      else $error("parity error missed");

   a_data_needs_ready: assert property (
      push && !rec.isAddr |-> !upInitiatorReadyN && !upTargetReadyN)
      else $error("data taken without both ready");

   ////////////////////////////////////////////////////////////////////////
   // reset release and defaults

   a_sync_release: assert property (
      $rose(rstN) |-> $past(rstSync_q[0]))
      else $error("reset released without first stage");

   a_stall_low_rst: assert property (
      $rose(rstN) |-> !upStall)
      else $error("stall set right after reset");

   a_out_zero_rst: assert property (
      $rose(rstN) |-> upAdOut == '0 && !upParityLineOut)
      else $error("driven values not cleared by reset");

   ////////////////////////////////////////////////////////////////////////
   // capture of address and data phases

   a_push_addr_rec: assert property (
      push && rec.isAddr |-> rec.word == upAdIn && rec.cmdBe == upCmdByteEnableIn)
      else $error("address record not raw");

   a_data_be_kept: assert property (
      push && !rec.isAddr |-> rec.cmdBe == upCmdByteEnableIn)
      else $error("byte enables not carried");

   a_cmd_held: assert property (
      s_q.phase == ubaf_pkg::UBAF_DATA |=> $stable(s_q.cmd))
      else $error("command changed inside a burst");

   a_lane_keep: assert property (
      push && !rec.isAddr && !upCmdByteEnableIn[0] |-> rec.word[7:0] == upAdIn[7:0])
      else $error("enabled lane altered");

   a_lane_low_off: assert property (
      push && !rec.isAddr && upCmdByteEnableIn[0] |-> rec.word[7:0] == 8'h00)
      else $error("disabled low lane passed");

   a_frame_tracked: assert property (
      !upFrameN |=> s_q.framePrev)
      else $error("frame not sampled at edge");

   a_wait_no_push: assert property (
      s_q.phase == ubaf_pkg::UBAF_DATA && (upInitiatorReadyN || upTargetReadyN) |-> !push)
      else $error("word taken in a wait state");

   a_last_to_idle: assert property (
      s_q.phase == ubaf_pkg::UBAF_DATA && upFrameN && dataDone
      |=> s_q.phase == ubaf_pkg::UBAF_IDLE)
      else $error("final phase did not end the cycle");

   a_burst_stays: assert property (
      s_q.phase == ubaf_pkg::UBAF_DATA && !upFrameN |=> s_q.phase == ubaf_pkg::UBAF_DATA)
      else $error("burst left while frame held");

   a_idle_no_push: assert property (
      s_q.phase == ubaf_pkg::UBAF_IDLE && upFrameN |-> !push)
      else $error("word taken with no cycle");

   ////////////////////////////////////////////////////////////////////////
   // downstream buffer

   a_head_holds: assert property (
      dnValid && !dnReady |=> dnValid && $stable(dnRec))
      else $error("head record changed before taken");

   a_empty_zero: assert property (
      !dnValid |-> dnRec == '0)
      else $error("empty buffer shows data");

   a_stall_full: assert property (
      upStall |-> dnValid)
      else $error("stall with empty buffer");

   ////////////////////////////////////////////////////////////////////////
   // driving and parity

   a_oe_pair: assert property (
      1'b1 |-> upAdOeN == upCmdByteEnableOeN)
      else $error("bus enables disagree");

   a_release_bus: assert property (
      !upMasterDrive |=> upAdOeN)
      else $error("bus driven without request");

   a_cbe_driven: assert property (
      upMasterDrive |=> upCmdByteEnableOut == $past(upDrive.cbe))
      else $error("command lines not driven");

   a_parity_float: assert property (
      upAdOeN |=> upParityLineOeN)
      else $error("parity driven with no word");

   a_no_false_err: assert property (
      sampleAd && upAdOeN ##1 upParityLineIn == $past(^{upAdIn, upCmdByteEnableIn})
      |=> !upParityErr)
      else $error("parity error on good word");

   a_err_needs_check: assert property (
      upParityErr |-> $past(s_q.chkPend))
      else $error("parity error without a check");

   c_addr_then_data: cover property (addrStart ##[1:4] dataDone);
   c_parity_err: cover property (upParityErr);
   c_fifo_full: cover property (upStall);
   c_master_word: cover property (upMasterDrive ##1 !upAdOeN ##1 !upParityLineOeN);
   c_burst_end: cover property (dataDone && upFrameN);

endmodule : ubaf_front
`default_nettype wire

// File: tb/ubaf_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// far side agent of the upstream bus: master and target in one
module ubaf_bus_model (
   input  wire logic        clk,
   output logic      [31:0] adDrv,
   output logic      [3:0]  cbeDrv,
   output logic             parDrv,
   output logic             frameN,
   output logic             irdyN,
   output logic             trdyN
);
   logic badQ;

   initial begin
      adDrv  = 32'h0000_0000;
      cbeDrv = 4'hf;
      parDrv = 1'b0;
      frameN = 1'b1;
      irdyN  = 1'b1;
      trdyN  = 1'b1;
      badQ   = 1'b0;
   end

   // even parity of the word one edge after it, flipped on demand
   always @(posedge clk) parDrv <= ^{adDrv, cbeDrv} ^ badQ;

   ////////////////////////////////////////
   // one bus cycle, launched just after an edge
   task automatic step(input logic fr, input logic ir, input logic tr,
                       input logic [31:0] w, input logic [3:0] c, input logic bad);
      @(posedge clk);
      frameN <= fr;
      irdyN  <= ir;
      trdyN  <= tr;
      adDrv  <= w;
      cbeDrv <= c;
      badQ   <= bad;
   endtask : step

   // released lines show the inverse, so a stale value never matches
   // inverse is taken after the edge, from the value that really stands
   task automatic idle();
      @(posedge clk);
      frameN <= 1'b1;
      irdyN  <= 1'b1;
      trdyN  <= 1'b1;
      adDrv  <= ~adDrv;
      cbeDrv <= ~cbeDrv;
      badQ   <= 1'b0;
   endtask : idle
endmodule : ubaf_bus_model
`default_nettype wire

// File: tb/upstream_bus_ad_reset_front_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
   $display("CHECK FAILED at %0t: value mismatch", $time); end end
module upstream_bus_ad_reset_front_tb;
   logic                  clk, nrst, md, dnReady, perr, stall, dnValid;
   logic [31:0]           adOut, adBus, adDrv;
   logic [3:0]            cbeOut, cbeBus, cbeDrv;
   logic                  adOeN, cbeOeN, parOut, parOeN, parBus, parDrv;
   logic                  frameN, irdyN, trdyN;
   ubaf_pkg::ubaf_drive_t drv;
   ubaf_pkg::ubaf_rec_t   dnRec;
   int                    failures = 0, checked = 0, cycles = 0, perrCount = 0;

   // wire level from the device's enables; the model's values stand when they float
   assign adBus  = (adOeN === ubaf_pkg::OE_DRIVE) ? adOut : adDrv;
   assign cbeBus = (cbeOeN === ubaf_pkg::OE_DRIVE) ? cbeOut : cbeDrv;
   assign parBus = (parOeN === ubaf_pkg::OE_DRIVE) ? parOut : parDrv;

   ubaf_front dut (.clk(clk), .nrst(nrst), .upAdIn(adBus), .upAdOut(adOut),
      .upAdOeN(adOeN), .upCmdByteEnableIn(cbeBus), .upCmdByteEnableOut(cbeOut),
      .upCmdByteEnableOeN(cbeOeN), .upParityLineIn(parBus), .upParityLineOut(parOut),
      .upParityLineOeN(parOeN), .upFrameN(frameN), .upInitiatorReadyN(irdyN),
      .upTargetReadyN(trdyN), .upMasterDrive(md), .upDrive(drv), .upParityErr(perr),
      .upStall(stall), .dnValid(dnValid), .dnReady(dnReady), .dnRec(dnRec));
   ubaf_bus_model m (.clk(clk), .adDrv(adDrv), .cbeDrv(cbeDrv), .parDrv(parDrv),
      .frameN(frameN), .irdyN(irdyN), .trdyN(trdyN));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // error pulses counted where settled
   always @(negedge clk) if (perr === 1'b1) perrCount++;
   // hang guard, far above the some 140 cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         failures++;
         results();
      end
   end

   ////////////////////////////////////////
   task automatic results();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : results

   // take one head record and compare it
   task automatic pop(input ubaf_pkg::ubaf_rec_t exp);
      int n;
      n = 0;
      @(negedge clk);
      while (dnValid !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      `CHK(dnRec, exp)
      @(posedge clk);
      dnReady <= 1'b1;
      @(posedge clk);
      dnReady <= 1'b0;
   endtask : pop

   // address, a wait state, then two data words
   task automatic burst();
      m.step(1'b0, 1'b1, 1'b1, 32'h8000_1230, 4'h7, 1'b0);
      m.step(1'b0, 1'b0, 1'b1, 32'hdead_beef, 4'h0, 1'b0);
      m.step(1'b0, 1'b0, 1'b0, 32'h1122_3344, 4'h0, 1'b0);
      m.step(1'b1, 1'b0, 1'b0, 32'haabb_ccdd, 4'h5, 1'b0);
      m.idle();
      pop('{1'b1, 4'h7, 32'h8000_1230});
      pop('{1'b0, 4'h0, 32'h1122_3344});
      pop('{1'b0, 4'h5, 32'haa00_cc00});
      @(negedge clk);
      `CHK(dnValid, 1'b0)
      `CHK(perrCount, 0)
   endtask : burst

   task automatic badParity();
      m.step(1'b0, 1'b1, 1'b1, 32'h0000_00f0, 4'h6, 1'b1);
      m.step(1'b1, 1'b0, 1'b0, 32'h0000_0001, 4'h0, 1'b0);
      m.idle();
      repeat (4) @(negedge clk);
      `CHK(perrCount, 1)
      pop('{1'b1, 4'h6, 32'h0000_00f0});
      pop('{1'b0, 4'h0, 32'h0000_0001});
   endtask : badParity

   task automatic masterDrive();
      @(posedge clk);
      md  <= 1'b1;
      drv <= '{32'h0f0f_1234, 4'h3};
      @(posedge clk);
      md <= 1'b0;
      @(negedge clk);
      `CHK(cbeOeN, ubaf_pkg::OE_DRIVE)
      `CHK(adBus, 32'h0f0f_1234)
      `CHK(cbeBus, 4'h3)
      @(negedge clk);
      `CHK(parOeN, ubaf_pkg::OE_DRIVE)
      `CHK(parBus, ^{32'h0f0f_1234, 4'h3})
      `CHK(adOeN, ubaf_pkg::OE_FLOAT)
   endtask : masterDrive

   // 33 words against 32 places, nothing drained meanwhile
   task automatic fillDrain();
      m.step(1'b0, 1'b1, 1'b1, 32'h4000_0000, 4'h7, 1'b0);
      for (int i = 0; i < 32; i++) m.step(i == 31, 1'b0, 1'b0, 32'(i), 4'h0, 1'b0);
      m.idle();
      @(negedge clk);
      `CHK(stall, 1'b1)
      pop('{1'b1, 4'h7, 32'h4000_0000});
      for (int i = 0; i < 31; i++) pop('{1'b0, 4'h0, 32'(i)});
      @(negedge clk);
      `CHK(dnValid, 1'b0)
      `CHK(stall, 1'b0)
   endtask : fillDrain

   // reset lands while driving and holding a record
   task automatic midReset();
      m.step(1'b0, 1'b1, 1'b1, 32'h0000_0100, 4'h7, 1'b0);
      m.idle();
      md  <= 1'b1;
      drv <= '{32'hffff_ffff, 4'hf};
      repeat (2) @(negedge clk);
      `CHK(dnValid, 1'b1)
      `CHK(adOeN, ubaf_pkg::OE_DRIVE)
      @(posedge clk);
      nrst <= 1'b0;
      #1;
      `CHK(adOeN, ubaf_pkg::OE_FLOAT)
      `CHK(parOeN, ubaf_pkg::OE_FLOAT)
      `CHK(dnValid, 1'b0)
      repeat (3) @(posedge clk);
      md   <= 1'b0;
      nrst <= 1'b1;
      repeat (3) @(negedge clk);
      `CHK(dnValid, 1'b0)
      `CHK(stall, 1'b0)
   endtask : midReset

   ////////////////////////////////////////
   initial begin
      nrst    = 1'b0;
      md      = 1'b0;
      drv     = '0;
      dnReady = 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK(adOeN, ubaf_pkg::OE_FLOAT)
      `CHK(cbeOeN, ubaf_pkg::OE_FLOAT)
      `CHK(parOeN, ubaf_pkg::OE_FLOAT)
      `CHK(dnRec, ubaf_pkg::ubaf_rec_t'(0))
      @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      burst();
      badParity();
      masterDrive();
      fillDrain();
      midReset();
      results();
   end
endmodule : upstream_bus_ad_reset_front_tb
`default_nettype wire
